// ### hw/pmode_map.vh
/*
 * Register map, field layout, state and timing constants for the power
 * mode controller. Assumes inclusion by bare name from hw/ design files.
 */
`ifndef PMODE_MAP_VH
`define PMODE_MAP_VH

// Register byte offsets
`define OFS_PROT 5'h00
`define OFS_CTRL 5'h04
`define OFS_STAT 5'h08
`define OFS_RSRC 5'h0C
`define OFS_EVT 5'h10

// Mode protection register fields
`define PROT_ALLOW_RET 1
`define PROT_ALLOW_LP 5

// Mode control register fields
`define CTRL_STOP_MODE_SELECT_LO 0
`define CTRL_ABORT 3
`define CTRL_RUN_MODE_SELECT_LO 5

// Reset source register fields
`define RSRC_WAKEUP 0
`define RSRC_PIN 6

// Field encodings
`define RUN_MODE_SELECT_RUN 2'h0
`define RUN_MODE_SELECT_LP 2'h2
`define STOP_MODE_SELECT_NORMAL 3'h0
`define STOP_MODE_SELECT_LPSTOP 3'h2
`define STOP_MODE_SELECT_RETAIN 3'h3

// Mode status readback codes
`define STAT_RUN 8'h01
`define STAT_STOP 8'h02
`define STAT_LPRUN 8'h04
`define STAT_LPWAIT 8'h08
`define STAT_LPSTOP 8'h10
`define STAT_RETAIN 8'h20
`define STAT_WAIT 8'h40

// Controller states
`define ST_RUN 4'h0
`define ST_TO_LPRUN 4'h1
`define ST_LPRUN 4'h2
`define ST_TO_RUN 4'h3
`define ST_WAIT 4'h4
`define ST_LPWAIT 4'h5
`define ST_STOP_ENTRY 4'h6
`define ST_STOP_REG 4'h7
`define ST_STOP 4'h8
`define ST_LPSTOP 4'h9
`define ST_RETAIN 4'hA
`define ST_STOP_EXIT 4'hB

// Reset values
`define PROT_RST 8'h00
`define CTRL_RST 8'h00

// Vector fetch and link register values at processor release
`define VEC_SP_OFS 32'h00000000
`define VEC_PC_OFS 32'h00000004
`define LINK_RST 32'hFFFFFFFF

// Regulator settle time in ns and its cycle count at 25 MHz
`define REG_SETTLE_NS 400
`define CLK_NS 40
`define REG_SETTLE_CYC ((`REG_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### hw/pm_axil_slave.v
/*
 * AXI4-Lite slave front end: accepts one write and one read at a time,
 * address and data in either order, and presents simple strobes.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module pm_axil_slave (
	input wire clk,
	input wire rst,
	input wire [4:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [4:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	output wire wr_en,
	output wire [4:0] wr_addr,
	output wire [31:0] wr_data,
	output wire [3:0] wr_strb,
	input wire wr_ok,
	output wire rd_en,
	output wire [4:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_ok
);
	reg aw_hold_r;
	reg w_hold_r;
	reg [4:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	assign awready = !aw_hold_r && !bvalid;
	assign wready = !w_hold_r && !bvalid;
	assign wr_en = aw_hold_r && w_hold_r;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_data_r;
	assign wr_strb = w_strb_r;
	assign arready = !rvalid;
	assign rd_en = arvalid && !rvalid;
	assign rd_addr = araddr;

	always @(posedge clk) begin
		if (rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 5'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h00000000;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			if (wr_en) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (rd_en) begin
				rvalid <= 1'b1;
				rdata <= rd_ok ? rd_data : 32'h00000000;
				rresp <= rd_ok ? 2'h0 : 2'h2;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule // pm_axil_slave
`default_nettype wire

// ### hw/pm_settle_timer.v
/*
 * Regulator settle timer: a start pulse loads the count, done pulses once
 * when it expires. Assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module pm_settle_timer (
	input wire clk,
	input wire rst,
	input wire start,
	output wire busy,
	output wire done
);
	`include "pmode_map.vh"
	localparam integer SETTLE_I = `REG_SETTLE_CYC;
	localparam [7:0] SETTLE = SETTLE_I[7:0];
	reg [7:0] cnt_r;

	assign busy = (cnt_r != 8'h00);
	assign done = (cnt_r == 8'h01);

	always @(posedge clk) begin
		if (rst) begin
			cnt_r <= 8'h00;
		end else if (start) begin
			cnt_r <= SETTLE;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule // pm_settle_timer
`default_nettype wire

// ### hw/power_mode_controller.v
/*
 * Power mode controller: run, low-power run, wait, low-power wait, normal
 * stop, low-power stop and retention stop, with register access over
 * AXI4-Lite. Assumes core sleep, deep-sleep, interrupt and wakeup inputs
 * are synchronous to REF_CLK and that RESET covers every chip reset.
 */
// Summary of operation
// - Reset enters run; strap may request low-power run
// - Core boot uses stack/pc vectors, all-ones link
// - Low-power run needs allow bit and select 10b
// - Flash program/erase blocked in low-power run
// - Low-power run puts regulator in stop regulation
// - Clearing select returns to run; status after regulation
// - Plain sleep from run enters wait
// - Interrupt in wait returns to run
// - Reset in wait or stop exits to run
// - Plain sleep from low-power run enters low-power wait
// - Interrupt in low-power wait returns to low-power run
// - Reset in low-power wait exits to run
// - Stop variant chosen by fields on deep sleep
// - Interrupt in normal stop wakes to run
// - Low-power stop entry conditions by stop select field
// - Low-power stop from run always exits to run
// - Low-power stop keeps regulation, interrupt to low-power run
// - Retention stop from run or low-power run
// - Retention wakeup returns to entry mode, wakeup pending
// - Reset pin in retention sets pin and wakeup flags
// - Retention needs allow bit, select 011, deep sleep
// - Interrupt before regulation aborts stop, sets abort flag
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller (
	input wire REF_CLK,
	input wire RESET,
	input wire RESET_PIN_EVENT,
	input wire BOOT_LP_STRAP,
	input wire CORE_SLEEP,
	input wire DEEP_SLEEP,
	input wire IRQ,
	input wire ASYNC_IRQ,
	input wire WAKEUP_EVENT,
	input wire [4:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output wire [1:0] S_AXI_BRESP,
	output wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [4:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0] S_AXI_RRESP,
	output wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	output reg CORE_CLK_EN,
	output reg SYS_CLK_EN,
	output reg REG_STOP_MODE,
	output reg RETENTION_HOLD,
	output reg FLASH_PE_ALLOW,
	output reg WAKEUP_IRQ_PEND,
	output reg CORE_RELEASE,
	output reg [31:0] BOOT_SP_ADDR,
	output reg [31:0] BOOT_PC_ADDR,
	output reg [31:0] BOOT_LINK_VAL
);
	`include "pmode_map.vh"

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg allow_lp_r;
	reg allow_ret_r;
	reg [1:0] run_mode_select_r;
	reg [2:0] stop_mode_select_r;
	reg stop_abort_flag_r;
	reg [7:0] mode_status_r;
	reg [7:0] status_nxt;
	reg from_lprun_r;
	reg rsrc_pin_r;
	reg rsrc_wakeup_r;
	reg strap_seen_r;
	reg timer_start;
	reg set_abort;
	reg set_pin_src;
	reg latch_origin;
	reg origin_nxt;
	reg stop_target_r;
	reg [3:0] stop_target_st_r;
	reg [3:0] target_nxt;

	wire wr_en;
	wire [4:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire rd_en;
	wire [4:0] rd_addr;
	reg [31:0] rd_data;
	reg wr_ok;
	reg rd_ok;
	wire settle_busy;
	wire settle_done;

	// Mapped offset check shared by both bus paths
	function mapped;
		input [4:0] a;
		begin
			mapped = (a == `OFS_PROT) || (a == `OFS_CTRL) || (a == `OFS_STAT) ||
				(a == `OFS_RSRC) || (a == `OFS_EVT);
		end
	endfunction

	pm_axil_slave u_bus (
		.clk(REF_CLK),
		.rst(RESET),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	pm_settle_timer u_settle (
		.clk(REF_CLK),
		.rst(RESET),
		.start(timer_start),
		.busy(settle_busy),
		.done(settle_done)
	);

	always @* begin
		wr_ok = mapped(wr_addr);
		rd_ok = mapped(rd_addr);
		rd_data = 32'h00000000;
		case (rd_addr)
			`OFS_PROT: begin
				rd_data[`PROT_ALLOW_LP] = allow_lp_r;
				rd_data[`PROT_ALLOW_RET] = allow_ret_r;
			end
			`OFS_CTRL: begin
				rd_data[`CTRL_RUN_MODE_SELECT_LO +: 2] = run_mode_select_r;
				rd_data[`CTRL_STOP_MODE_SELECT_LO +: 3] = stop_mode_select_r;
				rd_data[`CTRL_ABORT] = stop_abort_flag_r;
			end
			`OFS_STAT: rd_data[7:0] = mode_status_r;
			`OFS_RSRC: begin
				rd_data[`RSRC_PIN] = rsrc_pin_r;
				rd_data[`RSRC_WAKEUP] = rsrc_wakeup_r;
			end
			`OFS_EVT: rd_data[0] = WAKEUP_IRQ_PEND;
			default: rd_data = 32'h00000000;
		endcase
	end

	// Next-state logic for the single mode register
	always @* begin
		state_nxt = state_r;
		status_nxt = mode_status_r;
		timer_start = 1'b0;
		set_abort = 1'b0;
		set_pin_src = 1'b0;
		latch_origin = 1'b0;
		origin_nxt = from_lprun_r;
		target_nxt = stop_target_st_r;
		case (state_r)
			`ST_RUN: begin
				status_nxt = `STAT_RUN;
				if (strap_seen_r && allow_lp_r && run_mode_select_r == `RUN_MODE_SELECT_LP) begin
					state_nxt = `ST_TO_LPRUN;
					timer_start = 1'b1;
				end else if (CORE_SLEEP && !DEEP_SLEEP) begin
					state_nxt = `ST_WAIT;
				end else if (CORE_SLEEP && DEEP_SLEEP) begin
					latch_origin = 1'b1;
					origin_nxt = 1'b0;
					state_nxt = `ST_STOP_ENTRY;
					if (allow_ret_r && stop_mode_select_r == `STOP_MODE_SELECT_RETAIN)
						target_nxt = `ST_RETAIN;
					else if (allow_lp_r && stop_mode_select_r == `STOP_MODE_SELECT_LPSTOP)
						target_nxt = `ST_LPSTOP;
					else
						target_nxt = `ST_STOP;
				end
			end
			`ST_TO_LPRUN: begin
				if (settle_done) begin
					state_nxt = `ST_LPRUN;
					status_nxt = `STAT_LPRUN;
				end
			end
			`ST_LPRUN: begin
				if (run_mode_select_r == `RUN_MODE_SELECT_RUN) begin
					state_nxt = `ST_TO_RUN;
					timer_start = 1'b1;
				end else if (CORE_SLEEP && !DEEP_SLEEP) begin
					state_nxt = `ST_LPWAIT;
					status_nxt = `STAT_LPWAIT;
				end else if (CORE_SLEEP && DEEP_SLEEP) begin
					latch_origin = 1'b1;
					origin_nxt = 1'b1;
					state_nxt = `ST_STOP_ENTRY;
					if (allow_ret_r && stop_mode_select_r == `STOP_MODE_SELECT_RETAIN)
						target_nxt = `ST_RETAIN;
					else if (stop_mode_select_r == `STOP_MODE_SELECT_LPSTOP || stop_mode_select_r == `STOP_MODE_SELECT_NORMAL)
						target_nxt = `ST_LPSTOP;
					else
						target_nxt = `ST_LPSTOP;
				end
			end
			`ST_TO_RUN: begin
				if (settle_done) begin
					state_nxt = `ST_RUN;
					status_nxt = `STAT_RUN;
				end
			end
			`ST_WAIT: begin
				status_nxt = `STAT_WAIT;
				if (IRQ)
					state_nxt = `ST_RUN;
			end
			`ST_LPWAIT: begin
				if (IRQ) begin
					state_nxt = `ST_LPRUN;
					status_nxt = `STAT_LPRUN;
				end
			end
			`ST_STOP_ENTRY: begin
				if (IRQ || ASYNC_IRQ) begin
					set_abort = 1'b1;
					state_nxt = from_lprun_r ? `ST_LPRUN : `ST_RUN;
				end else begin
					state_nxt = `ST_STOP_REG;
					timer_start = 1'b1;
				end
			end
			`ST_STOP_REG: begin
				// Interrupts are ignored until regulation settles
				if (settle_done) begin
					state_nxt = stop_target_st_r;
					if (stop_target_st_r == `ST_RETAIN)
						status_nxt = `STAT_RETAIN;
					else if (stop_target_st_r == `ST_LPSTOP)
						status_nxt = `STAT_LPSTOP;
					else
						status_nxt = `STAT_STOP;
				end
			end
			`ST_STOP: begin
				if (ASYNC_IRQ || IRQ)
					state_nxt = `ST_RUN;
			end
			`ST_LPSTOP: begin
				if (ASYNC_IRQ || IRQ) begin
					state_nxt = from_lprun_r ? `ST_LPRUN : `ST_STOP_EXIT;
					timer_start = !from_lprun_r;
					status_nxt = from_lprun_r ? `STAT_LPRUN : mode_status_r;
				end
			end
			`ST_RETAIN: begin
				if (RESET_PIN_EVENT) begin
					set_pin_src = 1'b1;
					state_nxt = `ST_RUN;
					status_nxt = `STAT_RUN;
				end else if (WAKEUP_EVENT) begin
					state_nxt = from_lprun_r ? `ST_LPRUN : `ST_STOP_EXIT;
					timer_start = !from_lprun_r;
					status_nxt = from_lprun_r ? `STAT_LPRUN : mode_status_r;
				end
			end
			`ST_STOP_EXIT: begin
				if (settle_done) begin
					state_nxt = `ST_RUN;
					status_nxt = `STAT_RUN;
				end
			end
			default: begin
				state_nxt = `ST_RUN;
				status_nxt = `STAT_RUN;
			end
		endcase
	end

	always @(posedge REF_CLK) begin
		if (RESET) begin
			state_r <= `ST_RUN;
			mode_status_r <= `STAT_RUN;
			allow_lp_r <= 1'b0;
			allow_ret_r <= 1'b0;
			run_mode_select_r <= `RUN_MODE_SELECT_RUN;
			stop_mode_select_r <= `STOP_MODE_SELECT_NORMAL;
			stop_abort_flag_r <= 1'b0;
			from_lprun_r <= 1'b0;
			stop_target_r <= 1'b0;
			stop_target_st_r <= `ST_STOP;
			strap_seen_r <= 1'b0;
			WAKEUP_IRQ_PEND <= 1'b0;
		end else begin
			state_r <= state_nxt;
			mode_status_r <= status_nxt;
			stop_target_st_r <= target_nxt;
			stop_target_r <= (target_nxt == `ST_RETAIN);
			if (latch_origin)
				from_lprun_r <= origin_nxt;
			// Strap sampled on the first cycle after release
			if (!strap_seen_r) begin
				strap_seen_r <= 1'b1;
				if (BOOT_LP_STRAP) begin
					allow_lp_r <= 1'b1;
					run_mode_select_r <= `RUN_MODE_SELECT_LP;
				end
			end else if (wr_en && wr_addr == `OFS_PROT && wr_strb[0]) begin
				allow_lp_r <= wr_data[`PROT_ALLOW_LP];
				allow_ret_r <= wr_data[`PROT_ALLOW_RET];
			end
			if (strap_seen_r && wr_en && wr_addr == `OFS_CTRL && wr_strb[0]) begin
				// Low-power select only takes when allowed
				if (wr_data[`CTRL_RUN_MODE_SELECT_LO +: 2] != `RUN_MODE_SELECT_LP || allow_lp_r)
					run_mode_select_r <= wr_data[`CTRL_RUN_MODE_SELECT_LO +: 2];
				stop_mode_select_r <= wr_data[`CTRL_STOP_MODE_SELECT_LO +: 3];
			end
			if (set_abort)
				stop_abort_flag_r <= 1'b1;
			else if (latch_origin)
				stop_abort_flag_r <= 1'b0;
			// Wakeup pending set wins over a software clear
			if (state_r == `ST_RETAIN && WAKEUP_EVENT && !RESET_PIN_EVENT)
				WAKEUP_IRQ_PEND <= 1'b1;
			else if (wr_en && wr_addr == `OFS_EVT && wr_strb[0] && wr_data[0])
				WAKEUP_IRQ_PEND <= 1'b0;
		end
	end

	// Reset source flags clear on RESET; a pin exit from retention sets both and wins over RESET
	always @(posedge REF_CLK) begin
		if (set_pin_src) begin
			rsrc_pin_r <= 1'b1;
			rsrc_wakeup_r <= 1'b1;
		end else if (RESET) begin
			rsrc_pin_r <= 1'b0;
			rsrc_wakeup_r <= 1'b0;
		end else if (wr_en && wr_addr == `OFS_RSRC && wr_strb[0]) begin
			if (wr_data[`RSRC_PIN])
				rsrc_pin_r <= 1'b0;
			if (wr_data[`RSRC_WAKEUP])
				rsrc_wakeup_r <= 1'b0;
		end
	end

	// Clock, regulator and flash controls registered from the mode
	always @(posedge REF_CLK) begin
		if (RESET) begin
			CORE_CLK_EN <= 1'b0;
			SYS_CLK_EN <= 1'b1;
			REG_STOP_MODE <= 1'b0;
			RETENTION_HOLD <= 1'b0;
			FLASH_PE_ALLOW <= 1'b1;
			CORE_RELEASE <= 1'b0;
			BOOT_SP_ADDR <= `VEC_SP_OFS;
			BOOT_PC_ADDR <= `VEC_PC_OFS;
			BOOT_LINK_VAL <= `LINK_RST;
		end else begin
			CORE_RELEASE <= 1'b1;
			CORE_CLK_EN <= (state_nxt == `ST_RUN) || (state_nxt == `ST_LPRUN) ||
				(state_nxt == `ST_TO_LPRUN) || (state_nxt == `ST_TO_RUN);
			SYS_CLK_EN <= !(state_nxt == `ST_STOP_REG || state_nxt == `ST_STOP ||
				state_nxt == `ST_LPSTOP || state_nxt == `ST_RETAIN);
			REG_STOP_MODE <= !(state_nxt == `ST_RUN || state_nxt == `ST_WAIT ||
				state_nxt == `ST_STOP_ENTRY || state_nxt == `ST_TO_LPRUN ||
				(state_nxt == `ST_STOP_REG && stop_target_st_r == `ST_STOP) ||
				state_nxt == `ST_STOP);
			RETENTION_HOLD <= (state_nxt == `ST_RETAIN);
			FLASH_PE_ALLOW <= (state_nxt == `ST_RUN) && (mode_status_r == `STAT_RUN);
		end
	end
endmodule // power_mode_controller
`default_nettype wire

// ### bench/pm_mode_checker.sv
/*
 * Concurrent checks on the power mode controller's top-level ports.
 * Assumes a single REF_CLK domain and the synchronous active-high RESET.
 */
`include "pmode_map.vh"
`timescale 1ns/1ns
`default_nettype none
module pm_mode_checker (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic RESET_PIN_EVENT,
	input wire logic DEEP_SLEEP,
	input wire logic IRQ,
	input wire logic WAKEUP_EVENT,
	input wire logic CORE_CLK_EN,
	input wire logic SYS_CLK_EN,
	input wire logic REG_STOP_MODE,
	input wire logic RETENTION_HOLD,
	input wire logic FLASH_PE_ALLOW,
	input wire logic WAKEUP_IRQ_PEND,
	input wire logic CORE_RELEASE,
	input wire logic [31:0] BOOT_SP_ADDR,
	input wire logic [31:0] BOOT_PC_ADDR,
	input wire logic [31:0] BOOT_LINK_VAL
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	AST_RESET_RUN: assert property ($fell(RESET) |-> SYS_CLK_EN && !REG_STOP_MODE && FLASH_PE_ALLOW)
		else $error("not in full-power run after reset");
	AST_BOOT_VEC: assert property (CORE_RELEASE |-> BOOT_SP_ADDR == `VEC_SP_OFS && BOOT_PC_ADDR == `VEC_PC_OFS
		&& BOOT_LINK_VAL == `LINK_RST) else $error("boot vector values wrong");
	AST_NO_FLASH_LP: assert property (REG_STOP_MODE |-> !FLASH_PE_ALLOW)
		else $error("flash program allowed under stop regulation");
	AST_RET_HOLD: assert property (RETENTION_HOLD |-> !CORE_CLK_EN)
		else $error("core clock running in retention");
	AST_WAIT_CLKS: assert property ($fell(CORE_CLK_EN) && !DEEP_SLEEP |-> SYS_CLK_EN)
		else $error("system clocks stopped on plain sleep");
	AST_WAIT_WAKE: assert property (!CORE_CLK_EN && SYS_CLK_EN && !DEEP_SLEEP && IRQ |-> ##[1:4] CORE_CLK_EN)
		else $error("interrupt did not end wait");
	AST_ABORT_WAKE: assert property ($fell(CORE_CLK_EN) && DEEP_SLEEP && IRQ |-> ##[1:4] CORE_CLK_EN)
		else $error("interrupt did not abort stop entry");
	AST_PIN_EXIT: assert property (RETENTION_HOLD && RESET_PIN_EVENT |-> ##[1:14] (CORE_CLK_EN && !RETENTION_HOLD))
		else $error("reset pin did not end retention");
	AST_RET_PEND: assert property ($fell(RETENTION_HOLD) && WAKEUP_EVENT && !RESET_PIN_EVENT |-> ##[0:12] WAKEUP_IRQ_PEND)
		else $error("no pending wakeup interrupt");
endmodule // pm_mode_checker
bind power_mode_controller pm_mode_checker u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .RESET_PIN_EVENT(RESET_PIN_EVENT),
	.DEEP_SLEEP(DEEP_SLEEP), .IRQ(IRQ), .WAKEUP_EVENT(WAKEUP_EVENT), .CORE_CLK_EN(CORE_CLK_EN),
	.SYS_CLK_EN(SYS_CLK_EN), .REG_STOP_MODE(REG_STOP_MODE), .RETENTION_HOLD(RETENTION_HOLD),
	.FLASH_PE_ALLOW(FLASH_PE_ALLOW), .WAKEUP_IRQ_PEND(WAKEUP_IRQ_PEND), .CORE_RELEASE(CORE_RELEASE),
	.BOOT_SP_ADDR(BOOT_SP_ADDR), .BOOT_PC_ADDR(BOOT_PC_ADDR), .BOOT_LINK_VAL(BOOT_LINK_VAL));
`default_nettype wire

// ### bench/core_wake_model.sv
/*
 * Core sleep and wakeup source model: lines 0 sleep, 1 deep, 2 irq,
 * 3 async irq, 4 wakeup event, 5 reset pin. Assumes pulsed requests.
 */
`timescale 1ns/1ns
`default_nettype none
module core_wake_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_clk_en,
	input wire logic deep_lvl,
	input wire logic [4:0] req,
	output logic [5:0] lines
);
	logic prev_r;
	always @(posedge clk) begin
		prev_r <= core_clk_en;
		if (rst) begin
			lines <= 6'h00;
		end else begin
			// Clock monitors are taken as off before any low mode request
			// Deep flag is a software level set before sleeping
			lines[1] <= deep_lvl;
			// Sleep request held until the core clock stops
			lines[0] <= (lines[0] && !(prev_r && !core_clk_en)) || req[0];
			// Wake sources stay up until the core clock returns
			if (core_clk_en && !prev_r) begin
				lines[5:2] <= 4'h0;
			end else begin
				lines[5:2] <= lines[5:2] | req[4:1];
			end
		end
	end
endmodule // core_wake_model
`default_nettype wire

// ### bench/tb_top.sv
/*
 * Self-checking bench for the power mode controller over AXI4-Lite.
 * Assumes the core_wake_model partner and the bound checker.
 */
`include "pmode_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	reg REF_CLK = 1'b0;
	reg RESET = 1'b1;
	reg strap = 1'b0;
	reg deep = 1'b0;
	reg [4:0] req = 5'h00;
	reg [4:0] awa = 5'h00;
	reg [4:0] ara = 5'h00;
	reg [31:0] wd = 32'h00000000;
	reg awv = 1'b0;
	reg wv = 1'b0;
	reg arv = 1'b0;
	reg [31:0] v;
	reg [1:0] rr;
	reg [7:0] sel [0:2];
	reg [7:0] st [0:2];
	reg [4:0] wk [0:2];
	integer failures = 0;
	integer checks = 0;
	integer cyc = 0;
	integer i;
	wire [5:0] ln;
	wire [1:0] bresp;
	wire [1:0] rresp;
	wire [31:0] rdata;
	wire [31:0] bsp;
	wire [31:0] bpc;
	wire [31:0] blk;
	wire awr, wrdy, bv, arr, rv, cce, sce, rsm, rh, fpa, wip, crel;
	always #20 REF_CLK = ~REF_CLK;
	core_wake_model u_core (.clk(REF_CLK), .rst(RESET), .core_clk_en(cce), .deep_lvl(deep), .req(req), .lines(ln));
	power_mode_controller u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .RESET_PIN_EVENT(ln[5]), .BOOT_LP_STRAP(strap),
		.CORE_SLEEP(ln[0]), .DEEP_SLEEP(ln[1]), .IRQ(ln[2]), .ASYNC_IRQ(ln[3]), .WAKEUP_EVENT(ln[4]),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .CORE_CLK_EN(cce), .SYS_CLK_EN(sce), .REG_STOP_MODE(rsm),
		.RETENTION_HOLD(rh), .FLASH_PE_ALLOW(fpa), .WAKEUP_IRQ_PEND(wip), .CORE_RELEASE(crel),
		.BOOT_SP_ADDR(bsp), .BOOT_PC_ADDR(bpc), .BOOT_LINK_VAL(blk));
	task print_verdict;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	always @(posedge REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			print_verdict;
		end
	end
	task chk(input [31:0] s, input [31:0] e);
		begin
			checks = checks + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("BAD %0t seen %h want %h", $time, s, e);
			end
		end
	endtask
	task wr(input [4:0] a, input [7:0] d);
		reg a_ok, w_ok, b_ok;
		begin
			awa <= a;
			wd <= {24'h000000, d};
			awv <= 1'b1;
			wv <= 1'b1;
			b_ok = 1'b0;
			while (!b_ok) begin
				// Handshakes judged on settled values before the taking edge
				@(negedge REF_CLK);
				a_ok = awv && awr;
				w_ok = wv && wrdy;
				b_ok = bv;
				@(posedge REF_CLK);
				if (a_ok) awv <= 1'b0;
				if (w_ok) wv <= 1'b0;
			end
		end
	endtask
	task rd(input [4:0] a);
		reg a_ok, r_ok;
		begin
			ara <= a;
			arv <= 1'b1;
			r_ok = 1'b0;
			while (!r_ok) begin
				@(negedge REF_CLK);
				a_ok = arv && arr;
				r_ok = rv;
				if (rv) begin
					v = rdata;
					rr = rresp;
				end
				@(posedge REF_CLK);
				if (a_ok) arv <= 1'b0;
			end
		end
	endtask
	task poll(input [7:0] c);
		integer n;
		begin
			n = 0;
			rd(`OFS_STAT);
			while (v[7:0] !== c && n < 30) begin
				rd(`OFS_STAT);
				n = n + 1;
			end
			chk(v, {24'h000000, c});
		end
	endtask
	task fire(input [4:0] m);
		begin
			req <= m;
			@(posedge REF_CLK);
			req <= 5'h00;
			@(posedge REF_CLK);
		end
	endtask
	task t_boot;
		begin
			chk(crel, 1);
			chk(bpc, 32'h00000004);
			poll(`STAT_RUN);
			chk(fpa, 1);
			rd(`OFS_PROT);
			chk(v[7:0], `PROT_RST);
			rd(5'h14);
			chk(rr, 2'h2);
			chk(v, 0);
			$display("t_boot done");
		end
	endtask
	task t_wait;
		begin
			fire(5'h01);
			poll(`STAT_WAIT);
			chk({cce, sce}, 2'h1);
			fire(5'h02);
			poll(`STAT_RUN);
			$display("t_wait done");
		end
	endtask
	task t_lprun;
		begin
			wr(`OFS_CTRL, 8'h40);
			repeat (15) @(posedge REF_CLK);
			poll(`STAT_RUN);
			wr(`OFS_PROT, 8'h22);
			wr(`OFS_CTRL, 8'h40);
			poll(`STAT_LPRUN);
			chk({rsm, fpa}, 2'h2);
			$display("t_lprun done");
		end
	endtask
	task t_lpmodes;
		begin
			fire(5'h01);
			poll(`STAT_LPWAIT);
			chk(rsm, 1);
			fire(5'h02);
			poll(`STAT_LPRUN);
			for (i = 0; i < 3; i = i + 1) begin
				wr(`OFS_CTRL, 8'h40 | sel[i]);
				deep <= 1'b1;
				fire(5'h01);
				poll(st[i]);
				chk(rsm, 1);
				fire(wk[i]);
				poll(`STAT_LPRUN);
				deep <= 1'b0;
			end
			chk(wip, 1);
			wr(`OFS_EVT, 8'h01);
			chk(wip, 0);
			$display("t_lpmodes done");
		end
	endtask
	task t_torun;
		begin
			wr(`OFS_CTRL, 8'h00);
			rd(`OFS_STAT);
			chk(v[7:0], `STAT_LPRUN);
			poll(`STAT_RUN);
			chk({rsm, fpa}, 2'h1);
			$display("t_torun done");
		end
	endtask
	task t_stops;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				wr(`OFS_CTRL, sel[i]);
				deep <= 1'b1;
				fire(5'h01);
				poll(i == 0 ? `STAT_STOP : st[i]);
				chk(sce, 0);
				fire(wk[i]);
				poll(`STAT_RUN);
				deep <= 1'b0;
			end
			$display("t_stops done");
		end
	endtask
	task t_abort;
		begin
			wr(`OFS_CTRL, 8'h00);
			deep <= 1'b1;
			fire(5'h03);
			poll(`STAT_RUN);
			deep <= 1'b0;
			rd(`OFS_CTRL);
			chk(v[3], 1);
			$display("t_abort done");
		end
	endtask
	task t_pin;
		begin
			wr(`OFS_CTRL, 8'h03);
			deep <= 1'b1;
			fire(5'h01);
			poll(`STAT_RETAIN);
			chk(rh, 1);
			fire(5'h10);
			poll(`STAT_RUN);
			deep <= 1'b0;
			rd(`OFS_RSRC);
			chk(v[7:0], 8'h41);
			wr(`OFS_RSRC, 8'h41);
			rd(`OFS_RSRC);
			chk(v[7:0], 8'h00);
			$display("t_pin done");
		end
	endtask
	task t_reset;
		begin
			fire(5'h01);
			poll(`STAT_WAIT);
			strap <= 1'b1;
			RESET <= 1'b1;
			repeat (2) @(posedge REF_CLK);
			RESET <= 1'b0;
			repeat (2) @(posedge REF_CLK);
			poll(`STAT_LPRUN);
			strap <= 1'b0;
			fire(5'h01);
			poll(`STAT_LPWAIT);
			RESET <= 1'b1;
			repeat (2) @(posedge REF_CLK);
			RESET <= 1'b0;
			repeat (2) @(posedge REF_CLK);
			poll(`STAT_RUN);
			chk(rsm, 0);
			$display("t_reset done");
		end
	endtask
	initial begin
		sel[0] = `STOP_MODE_SELECT_NORMAL;
		sel[1] = `STOP_MODE_SELECT_LPSTOP;
		sel[2] = `STOP_MODE_SELECT_RETAIN;
		st[0] = `STAT_LPSTOP;
		st[1] = `STAT_LPSTOP;
		st[2] = `STAT_RETAIN;
		wk[0] = 5'h04;
		wk[1] = 5'h04;
		wk[2] = 5'h08;
		repeat (6) @(posedge REF_CLK);
		RESET <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		t_boot;
		t_wait;
		t_lprun;
		t_lpmodes;
		t_torun;
		t_stops;
		t_abort;
		t_pin;
		t_reset;
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
